// file: design/bisr_params.svh
`ifndef BISR_PARAMS_SVH
`define BISR_PARAMS_SVH
`define BISR_OFFSET 8'h84
`define BISR_FUNC_LSB 0
`define BISR_DEV_LSB 3
`define BISR_BUS_LSB 8
`define BISR_W64_BIT 16
`define BISR_M133_BIT 17
`define BISR_FUNC_RST 3'h0
`define BISR_DEV_RST 5'h1f
`define BISR_BUS_RST 8'hff
`define BISR_TYPE0 2'h0
`define BISR_CMD_CFGWR 4'hb
`endif

// file: design/bisr_pkg.sv
package bisr_pkg;
    typedef struct packed {
        logic [3:0] cmd;
        logic idsel;
        logic [31:0] ad;
    } bisr_addr_s;
    typedef struct packed {
        logic [7:0] bus;
        logic [4:0] dev;
        logic [2:0] func;
    } bisr_cid_s;
    typedef struct packed {
        logic [4:0] dev;
        logic [7:0] bus;
        logic [31:0] rdata;
    } bisr_state_s;
endpackage

// file: design/bisr_status_reg.sv
`timescale 1ns/10ps
`include "bisr_params.svh"
module bisr_status_reg #(
    parameter logic [2:0] FUNC_NUM = `BISR_FUNC_RST,
    parameter logic IS_64BIT = 1'b0,
    parameter logic IS_133MHZ = 1'b0
) (
    // clock, reset and enable
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic en_i,
    // address phase, sampled in the bus clock domain
    input wire logic addr_valid_i,
    input wire bisr_pkg::bisr_addr_s addr_i,
    // primary bus number from the type-1 header
    input wire logic [7:0] pri_bus_i,
    // register read port
    input wire logic [7:0] rd_offset_i,
    output logic [31:0] rd_data_o,
    // completer id for split completions and mixed-mode use
    output bisr_pkg::bisr_cid_s cid_o
);
    import bisr_pkg::*;

    // the read word packs the fields side by side; a moved field would overlap its neighbour
    if (`BISR_FUNC_LSB != 0)
    begin : g_bad_func_lsb
        $error("bisr: function field must start at bit 0");
    end

    if (`BISR_DEV_LSB != `BISR_FUNC_LSB + 3)
    begin : g_bad_dev_lsb
        $error("bisr: device field must sit just above the function field");
    end

    if (`BISR_BUS_LSB != `BISR_DEV_LSB + 5)
    begin : g_bad_bus_lsb
        $error("bisr: bus field must sit just above the device field");
    end

    if (`BISR_W64_BIT != `BISR_BUS_LSB + 8)
    begin : g_bad_w64_bit
        $error("bisr: 64-bit flag must sit just above the bus field");
    end

    if (`BISR_M133_BIT != `BISR_W64_BIT + 1)
    begin : g_bad_m133_bit
        $error("bisr: 133 MHz flag must sit just above the 64-bit flag");
    end

    if (`BISR_M133_BIT > 31)
    begin : g_bad_word_width
        $error("bisr: flags must fit in the 32-bit read word");
    end

    if ((`BISR_OFFSET & 8'h03) != 8'h00)
    begin : g_bad_offset
        $error("bisr: register offset must be dword aligned");
    end

    if (`BISR_TYPE0 != 2'h0)
    begin : g_bad_type0
        $error("bisr: type-0 accesses carry zero in the two low address bits");
    end

    if (`BISR_FUNC_RST != 3'h0)
    begin : g_bad_func_rst
        $error("bisr: the function number field resets to zero");
    end

    bisr_state_s s_q;
    bisr_state_s s_d;

    logic hit;
    logic rd_sel;

    // only type-0 config writes to our function may move the device number
    function automatic logic addressed(
        input bisr_addr_s a,
        input logic [2:0] fn
    );
        logic is_wr;
        logic is_t0;
        logic fn_ok;

        is_wr = (a.cmd == `BISR_CMD_CFGWR);
        is_t0 = (a.ad[1:0] == `BISR_TYPE0);
        fn_ok = (a.ad[10:8] == fn);

        addressed = is_wr && a.idsel && is_t0 && fn_ok;
    endfunction

    // a fresh capture replaces the stored device number, otherwise it holds
    function automatic logic [4:0] next_dev(
        input logic [4:0] cur,
        input logic take,
        input logic [4:0] ad_dev
    );
        logic [4:0] n;

        n = cur;
        if (take)
        begin
            n = ad_dev;
        end

        next_dev = n;
    endfunction

    // the mirror copies the header register every enabled clock, so it trails by one cycle
    function automatic logic [7:0] next_bus(
        input logic [7:0] hdr_bus
    );
        next_bus = hdr_bus;
    endfunction

    // only one dword offset answers; others read zero so neighbour words can be or-ed
    function automatic logic is_status_read(
        input logic [7:0] offset
    );
        is_status_read = (offset == `BISR_OFFSET);
    endfunction

    // bits above the two flags belong to the split error logic and read zero here
    function automatic logic [31:0] pack_word(
        input logic [2:0] fn,
        input logic [4:0] dev,
        input logic [7:0] bus,
        input logic w64,
        input logic m133
    );
        logic [31:0] w;

        w = 32'h0;

        w[`BISR_FUNC_LSB +: 3] = fn;
        w[`BISR_DEV_LSB +: 5] = dev;
        w[`BISR_BUS_LSB +: 8] = bus;
        w[`BISR_W64_BIT] = w64;
        w[`BISR_M133_BIT] = m133;

        pack_word = w;
    endfunction

    // read data is registered, so it shows the fields as they stood when the offset was seen
    function automatic logic [31:0] next_rdata(
        input logic sel,
        input bisr_state_s st,
        input logic [2:0] fn
    );
        logic [31:0] w;

        w = 32'h0;
        if (sel)
        begin
            w = pack_word(fn, st.dev, st.bus, IS_64BIT, IS_133MHZ);
        end

        next_rdata = w;
    endfunction

    // completer id as used for split completions and for mixed bus modes
    function automatic bisr_cid_s make_cid(
        input logic [7:0] bus,
        input logic [4:0] dev,
        input logic [2:0] fn
    );
        bisr_cid_s c;

        c.bus = bus;
        c.dev = dev;
        c.func = fn;

        make_cid = c;
    endfunction

    always_comb
    begin
        s_d = s_q;
        hit = 1'h0;
        rd_sel = 1'h0;

        // address phase decode
        if (addr_valid_i)
        begin
            hit = addressed(addr_i, FUNC_NUM);
        end

        // whatever register the write targets, the device number follows it
        s_d.dev = next_dev(s_q.dev, hit, addr_i.ad[15:11]);

        // second read location of the primary bus number
        s_d.bus = next_bus(pri_bus_i);

        // read port
        rd_sel = is_status_read(rd_offset_i);
        s_d.rdata = next_rdata(rd_sel, s_q, FUNC_NUM);
    end

    // en_i low freezes every field, the mirrored bus number too
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            s_q.dev <= `BISR_DEV_RST;
            s_q.bus <= `BISR_BUS_RST;
            s_q.rdata <= 32'h0;
        end
        else if (en_i)
        begin
            s_q <= s_d;
        end
    end

    assign rd_data_o = s_q.rdata;

    // the id follows stored fields, so a write's new device number shows one cycle later
    assign cid_o = make_cid(s_q.bus, s_q.dev, FUNC_NUM);
endmodule // bisr_status_reg

// file: verification/bisr_chk.sv
`timescale 1ns/10ps
module bisr_chk #(parameter logic [2:0] FUNC_NUM = 3'h0) (input wire logic clk_i, nrst_i, en_i,
addr_valid_i, input wire bisr_pkg::bisr_addr_s addr_i, input wire logic [7:0] pri_bus_i,
rd_offset_i, input wire logic [31:0] rd_data_o, input wire bisr_pkg::bisr_cid_s cid_o);
default clocking @(posedge clk_i); endclocking
default disable iff (!nrst_i);
wire r = en_i && rd_offset_i == 8'h84;
wire h = en_i && addr_valid_i && addr_i[36:32] == 5'h17 && addr_i[1:0] == 2'h0
    && addr_i[10:8] == FUNC_NUM;
a_fn_fix: assert property (cid_o[2:0] == FUNC_NUM) else $error("fn");
a_dev_cap: assert property (h |=> cid_o[7:3] == $past(addr_i[15:11])) else $error("dv");
a_dev_keep: assert property (!h |=> $stable(cid_o[7:3])) else $error("kp");
a_bus_mir: assert property (en_i |=> cid_o[15:8] == $past(pri_bus_i)) else $error("bs");
a_rd_id: assert property (r |=> rd_data_o[15:0] == $past(cid_o)) else $error("id");
a_flag_w64: assert property (r |=> !rd_data_o[16]) else $error("w");
a_flag_fast: assert property (r |=> rd_data_o[31:17] == 15'h0) else $error("m");
a_off_zero: assert property (en_i && !r |=> rd_data_o == 32'h0) else $error("z");
c_h: cover property (h);
c_r: cover property (r);
c_v: cover property (addr_valid_i && !h);
endmodule // bisr_chk

// file: verification/bisr_host.sv
`timescale 1ns/10ps
module bisr_host (input wire logic clk_i, output bisr_pkg::bisr_addr_s a_o, output logic v_o);
initial v_o = 1'h0;
// one address phase per call; released lines carry the inverse, not stale data
task automatic cfg(input bisr_pkg::bisr_addr_s a);
@(negedge clk_i) {v_o, a_o} = {1'h1, a};
@(negedge clk_i) {v_o, a_o} = {1'h0, ~a};
endtask
endmodule // bisr_host

// file: verification/test_bridge_identity_status_register.sv
`timescale 1ns/10ps
module test_bridge_identity_status_register;
    logic clk_i = 1'h0;
    logic nrst_i = 1'h0;
    logic en = 1'h1;
    logic v;
    logic [7:0] off = 8'h84;
    logic [7:0] pri = 8'h3c;
    logic [31:0] rd;
    bisr_pkg::bisr_addr_s a;
    bisr_pkg::bisr_cid_s cid;
    int fail_count = 0;
    int n_compared = 0;
    int cyc = 0;
    // each row: command, idsel, address phase, then the device number it should leave behind
    logic [41:0] rows [6] = '{{4'hb, 33'h1_0000_2800, 5'h05}, {4'ha, 33'h1_0000_5000, 5'h05},
        {4'hb, 33'h0_0000_5000, 5'h05}, {4'hb, 33'h1_0000_5001, 5'h05},
        {4'hb, 33'h1_0000_5100, 5'h05}, {4'hb, 33'h1_0000_00fc, 5'h00}};
    always #2 clk_i = ~clk_i;
    bisr_host host_u (.clk_i(clk_i), .a_o(a), .v_o(v));
    bisr_status_reg dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .en_i(en), .addr_valid_i(v),
        .addr_i(a), .pri_bus_i(pri), .rd_offset_i(off), .rd_data_o(rd), .cid_o(cid));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e)
        begin
            fail_count++;
            $display("Error %0t: saw %h, expected %h", $time, s, e);
        end
    endtask
    task automatic stop_test;
        if (fail_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // the run needs about 46 clocks; a hang ends here as a failure
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 500)
        begin
            fail_count++;
            stop_test();
        end
    end
    initial
    begin
        repeat (6) @(negedge clk_i);
        chk(cid, 32'hfff8);
        chk(rd, 32'h0);
        nrst_i = 1'h1;
        foreach (rows[i])
        begin
            host_u.cfg(rows[i][41:5]);
            repeat (2) @(negedge clk_i);
            chk(rd, {16'h0, 8'h3c, rows[i][4:0], 3'h0});
            chk(cid, {16'h0, 8'h3c, rows[i][4:0], 3'h0});
        end
        // the mirror trails the header register by one clock, the read word by two
        pri = 8'h5a;
        @(negedge clk_i);
        chk(cid, {16'h0, 8'h5a, 8'h0});
        chk(rd, {16'h0, 8'h3c, 8'h0});
        @(negedge clk_i);
        chk(rd, {16'h0, 8'h5a, 8'h0});
        // a low enable must hold off both a matching write and the mirror
        en = 1'h0;
        pri = 8'h11;
        host_u.cfg(rows[0][41:5]);
        @(negedge clk_i);
        chk(cid, {16'h0, 8'h5a, 8'h0});
        en = 1'h1;
        pri = 8'h5a;
        host_u.cfg(rows[0][41:5]);
        repeat (2) @(negedge clk_i);
        chk(cid, {16'h0, 8'h5a, 5'h05, 3'h0});
        // reset in mid-run brings back the reset fields
        nrst_i = 1'h0;
        @(negedge clk_i);
        chk(cid, 32'hfff8);
        chk(rd, 32'h0);
        nrst_i = 1'h1;
        host_u.cfg(rows[5][41:5]);
        repeat (2) @(negedge clk_i);
        chk(rd, {16'h0, 8'h5a, 8'h0});
        off = 8'h80;
        repeat (2) @(negedge clk_i);
        chk(rd, 32'h0);
        stop_test();
    end
endmodule // test_bridge_identity_status_register
bind bisr_status_reg bisr_chk #(.FUNC_NUM(FUNC_NUM)) chk_u (.*);
